// file: src/bfs_pkg.sv
package bfs_pkg;
	// -----------------------------------------------------------------
	// apb map
	// -----------------------------------------------------------------
	localparam logic [7:0] ADDR_CONTROL      = 8'h00;
	localparam logic [7:0] ADDR_SINGLE_POLE  = 8'h04;
	localparam logic [7:0] ADDR_MULTI_POLE   = 8'h08;
	localparam logic [7:0] ADDR_LOW_CURRENT  = 8'h0C;
	localparam logic [7:0] ADDR_PULSE_MODE   = 8'h10;
	localparam logic [7:0] ADDR_BREAKER_FLT  = 8'h14;
	localparam logic [7:0] ADDR_REPEAT       = 8'h18;
	localparam logic [7:0] ADDR_RELEASE_SUP  = 8'h1C;
	localparam logic [7:0] ADDR_TWO_CHANNEL  = 8'h20;
	localparam logic [7:0] ADDR_STATUS       = 8'h24;
	localparam logic [7:0] ADDR_ERROR        = 8'h28;

	// -----------------------------------------------------------------
	// control fields
	// -----------------------------------------------------------------
	localparam int CTL_INIT_LSB   = 0;
	localparam int CTL_MODE_LSB   = 2;
	localparam int CTL_LOWCUR_BIT = 5;
	localparam int CTL_REP3P_BIT  = 6;
	localparam int CTL_PULSE_BIT  = 7;

	typedef enum logic [1:0] {
		BFS_SINGLE_CHANNEL_UNSUPERVISED,
		BFS_SINGLE_CHANNEL_SUPERVISED,
		BFS_DUAL_CHANNEL_UNSUPERVISED,
		BFS_DUAL_CHANNEL_SUPERVISED
	} bfs_init_t;

	typedef enum logic [2:0] {
		BFS_NON_EXISTENT,
		BFS_EXTERNAL,
		BFS_ZONE_UNBALANCE_MODE,
		BFS_TRIP_REP_UNBALANCE,
		BFS_CURRENT_QUERY,
		BFS_TRIP_REP_QUERY
	} bfs_mode_t;

	localparam bfs_init_t INIT_RESET = BFS_SINGLE_CHANNEL_SUPERVISED;
	localparam bfs_mode_t MODE_RESET = BFS_ZONE_UNBALANCE_MODE;

	// -----------------------------------------------------------------
	// delay settings in 10 ms steps: min, max, reset
	// -----------------------------------------------------------------
	localparam logic [10:0] DLY_MIN_5     = 11'd5;
	localparam logic [10:0] DLY_MIN_0     = 11'd0;
	localparam logic [10:0] DLY_MIN_2     = 11'd2;
	localparam logic [10:0] DLY_MIN_6     = 11'd6;
	localparam logic [10:0] DLY_MAX_1000  = 11'd1000;
	localparam logic [10:0] DLY_MAX_1500  = 11'd1500;
	localparam logic [10:0] DLY_MAX_100   = 11'd100;
	localparam logic [10:0] RST_POLE      = 11'd25;
	localparam logic [10:0] RST_PULSE     = 11'd50;
	localparam logic [10:0] RST_BREAKER   = 11'd10;
	localparam logic [10:0] RST_REPEAT    = 11'd12;
	localparam logic [10:0] RST_RELEASE   = 11'd1500;
	localparam logic [10:0] RST_TWO_CHAN  = 11'd6;

	// -----------------------------------------------------------------
	// timing
	// -----------------------------------------------------------------
	localparam int CLK_HZ         = 10_000_000;
	localparam int TICK_US        = 1000;
	localparam int TICK_CYCLES    = CLK_HZ / 1_000_000 * TICK_US;
	localparam int STEP_MS        = 10;
	localparam int QUERY_DROP_MS  = 25;
	localparam int UNBAL_DROP_MS  = 2;
	localparam int PULSE_MIN_MS   = 20;
	localparam int PULSE_MAX_MS   = 15000;
endpackage : bfs_pkg

// file: src/bfs_tick.sv
`timescale 1ns/10ps
`default_nettype none
module bfs_tick #(
	parameter int CYCLES = bfs_pkg::TICK_CYCLES
) (
	input  wire logic clk,
	input  wire logic reset,
	output logic      tick
);
	// the counter is 16 bits wide
	if (CYCLES < 2 || CYCLES > 65536) begin : g_bad_cycles
		$error("tick divider needs 2 to 65536 cycles");
	end

	logic [15:0] count;
	logic [15:0] next_count;
	logic        next_tick;

	always_comb begin
		next_tick  = (count == 16'(CYCLES - 1));
		next_count = next_tick ? 16'h0000 : count + 16'h0001;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			count <= 16'h0000;
			tick  <= 1'b0;
		end else begin
			count <= next_count;
			tick  <= next_tick;
		end
	end
endmodule : bfs_tick
`default_nettype wire

// file: src/bfs_timer.sv
`timescale 1ns/10ps
`default_nettype none
// counts ms ticks while run is high; clears when run falls
module bfs_timer (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        tick,
	input  wire logic        run,
	input  wire logic [14:0] limit_ms,
	output logic             expired
);
	logic [14:0] count;
	logic [14:0] next_count;
	logic        next_expired;

	always_comb begin
		next_count   = count;
		next_expired = 1'b0;
		if (!run) begin
			next_count = 15'h0000;
		end else begin
			if (tick && count < limit_ms) next_count = count + 15'h0001;
			next_expired = (next_count >= limit_ms);
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			count   <= 15'h0000;
			expired <= 1'b0;
		end else begin
			count   <= next_count;
			expired <= next_expired;
		end
	end
endmodule : bfs_timer
`default_nettype wire

// file: src/bfs_supervisor.sv
// How it works
// - single-channel settings start from the feeder start input alone
// - dual-channel settings also need the release input before starting
// - non-existent mode disables every trip output
// - query modes check current after delay; variant repeats trip first
// - unbalance mode is default; variant repeats trip first
// - external mode trips bus zone at once, no internal detection
// - query modes hold current through a 25 ms dropout window
// - unbalance mode uses a 2 ms dropout
// - low-current mode only when enabled, default off
// - low-current mode has no effect in external mode
// - single-pole repeat needs initiating phase plus another current
// - three-pole repeat needs initiating phase and earth current
// - trip repeat blocked by breaker-not-ready except low-current mode
// - single-pole faults delayed by single-pole delay
// - multi-pole faults delayed by multi-pole delay
// - repeat and failure delays start together; bus trip after second
// - low-current mode uses low-current delay
// - pulse mode delays feeder repeat by pulse-mode delay
// - breaker malfunction uses breaker-fault delay
// - trip repeat delayed by repeat delay
// - supervised release active too long raises an error
// - supervised dual-channel release must come within the two-channel window
// - low-current bus trip needs closed breaker, blocked by phase current
// - remote pulse outside 20 ms to 15 s raises timing error
// - breaker-not-ready replaces pole delays with breaker-fault delay
//
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module bfs_supervisor #(
	parameter int TICK_CYCLES = bfs_pkg::TICK_CYCLES
) (
	input  wire logic        CLK,
	input  wire logic        RESET,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic [31:0]      PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic [2:0]  START_PHASE,
	input  wire logic        START_THREE_POLE,
	input  wire logic        FAILURE_RELEASE_INPUT,
	input  wire logic        REMOTE_PULSE_INPUT,
	input  wire logic        BREAKER_NOT_READY_INPUT,
	input  wire logic        BREAKER_CLOSED,
	input  wire logic [2:0]  PHASE_ABOVE_THRESHOLD,
	input  wire logic [2:0]  PHASE_ABOVE_EARTH_THRESHOLD,
	input  wire logic        EARTH_ABOVE_THRESHOLD,
	output logic [2:0]       TRIP_REPEAT,
	output logic             BUS_ZONE_TRIP,
	output logic             TRANSFER_TRIP,
	output logic             RELEASE_ERROR,
	output logic             TWO_CHANNEL_ERROR,
	output logic             PULSE_ERROR
);
	// -----------------------------------------------------------------
	// helpers
	// -----------------------------------------------------------------
	function automatic logic [10:0] clamp(input logic [31:0] v, input logic [10:0] lo,
			input logic [10:0] hi);
		if (v < 32'(lo)) return lo;
		if (v > 32'(hi)) return hi;
		return v[10:0];
	endfunction : clamp

	function automatic logic [14:0] to_ms(input logic [10:0] steps);
		return 15'(steps * 15'(bfs_pkg::STEP_MS));
	endfunction : to_ms

	// -----------------------------------------------------------------
	// input synchronisers
	// -----------------------------------------------------------------
	localparam int NIN = 15;
	logic [NIN-1:0] sync_a;
	logic [NIN-1:0] sync_b;
	always_ff @(posedge CLK) begin
		if (RESET) begin
			sync_a <= '0;
			sync_b <= '0;
		end else begin
			sync_a <= {START_PHASE, START_THREE_POLE, FAILURE_RELEASE_INPUT,
				REMOTE_PULSE_INPUT, BREAKER_NOT_READY_INPUT, BREAKER_CLOSED,
				PHASE_ABOVE_THRESHOLD, PHASE_ABOVE_EARTH_THRESHOLD, EARTH_ABOVE_THRESHOLD};
			sync_b <= sync_a;
		end
	end
	logic [2:0] s_phase;
	logic       s_three;
	logic       s_rel;
	logic       s_pulse;
	logic       s_nready;
	logic       s_closed;
	logic [2:0] s_iph;
	logic [2:0] s_iph_ef;
	logic       s_ie;
	assign {s_phase, s_three, s_rel, s_pulse, s_nready, s_closed, s_iph, s_iph_ef, s_ie} = sync_b;

	// -----------------------------------------------------------------
	// registers
	// -----------------------------------------------------------------
	bfs_pkg::bfs_init_t init_sel;
	bfs_pkg::bfs_mode_t op_mode;
	logic        low_current_enable;
	logic        repeat_three_pole;
	logic        pulse_enable;
	logic [10:0] single_pole_delay;
	logic [10:0] multi_pole_delay;
	logic [10:0] low_current_delay;
	logic [10:0] pulse_mode_delay;
	logic [10:0] breaker_fault_delay;
	logic [10:0] repeat_delay;
	logic [10:0] release_supervision_time;
	logic [10:0] two_channel_window;

	// writes land on the edge that completes the access, once only
	logic wr;
	assign wr = PSEL && PENABLE && PREADY && PWRITE;

	always_ff @(posedge CLK) begin
		if (RESET) begin
			init_sel                 <= bfs_pkg::INIT_RESET;
			op_mode                  <= bfs_pkg::MODE_RESET;
			low_current_enable       <= 1'b0;
			repeat_three_pole        <= 1'b0;
			pulse_enable             <= 1'b0;
			single_pole_delay        <= bfs_pkg::RST_POLE;
			multi_pole_delay         <= bfs_pkg::RST_POLE;
			low_current_delay        <= bfs_pkg::RST_POLE;
			pulse_mode_delay         <= bfs_pkg::RST_PULSE;
			breaker_fault_delay      <= bfs_pkg::RST_BREAKER;
			repeat_delay             <= bfs_pkg::RST_REPEAT;
			release_supervision_time <= bfs_pkg::RST_RELEASE;
			two_channel_window       <= bfs_pkg::RST_TWO_CHAN;
		end else if (wr) begin
			unique case (PADDR)
				bfs_pkg::ADDR_CONTROL: begin
					init_sel <= bfs_pkg::bfs_init_t'(PWDATA[bfs_pkg::CTL_INIT_LSB +: 2]);
					// unknown mode codes fall back to the default mode
					if (PWDATA[bfs_pkg::CTL_MODE_LSB +: 3] > 3'd5)
						op_mode <= bfs_pkg::MODE_RESET;
					else
						op_mode <= bfs_pkg::bfs_mode_t'(PWDATA[bfs_pkg::CTL_MODE_LSB +: 3]);
					low_current_enable <= PWDATA[bfs_pkg::CTL_LOWCUR_BIT];
					repeat_three_pole  <= PWDATA[bfs_pkg::CTL_REP3P_BIT];
					pulse_enable       <= PWDATA[bfs_pkg::CTL_PULSE_BIT];
				end
				bfs_pkg::ADDR_SINGLE_POLE: single_pole_delay <=
					clamp(PWDATA, bfs_pkg::DLY_MIN_5, bfs_pkg::DLY_MAX_1000);
				bfs_pkg::ADDR_MULTI_POLE: multi_pole_delay <=
					clamp(PWDATA, bfs_pkg::DLY_MIN_5, bfs_pkg::DLY_MAX_1000);
				bfs_pkg::ADDR_LOW_CURRENT: low_current_delay <=
					clamp(PWDATA, bfs_pkg::DLY_MIN_5, bfs_pkg::DLY_MAX_1000);
				bfs_pkg::ADDR_PULSE_MODE: pulse_mode_delay <=
					clamp(PWDATA, bfs_pkg::DLY_MIN_5, bfs_pkg::DLY_MAX_1000);
				bfs_pkg::ADDR_BREAKER_FLT: breaker_fault_delay <=
					clamp(PWDATA, bfs_pkg::DLY_MIN_0, bfs_pkg::DLY_MAX_1000);
				bfs_pkg::ADDR_REPEAT: repeat_delay <=
					clamp(PWDATA, bfs_pkg::DLY_MIN_0, bfs_pkg::DLY_MAX_1000);
				bfs_pkg::ADDR_RELEASE_SUP: release_supervision_time <=
					clamp(PWDATA, bfs_pkg::DLY_MIN_2, bfs_pkg::DLY_MAX_1500);
				bfs_pkg::ADDR_TWO_CHANNEL: two_channel_window <=
					clamp(PWDATA, bfs_pkg::DLY_MIN_6, bfs_pkg::DLY_MAX_100);
				default: ;
			endcase
		end
	end

	// -----------------------------------------------------------------
	// initiation and current release
	// -----------------------------------------------------------------
	logic tick;
	bfs_tick #(.CYCLES(TICK_CYCLES)) u_tick (.clk(CLK), .reset(RESET), .tick(tick));

	logic two_channel;
	logic supervised;
	logic started;
	logic start_any;
	logic multi_pole;
	logic query_mode;
	logic repeat_mode;
	logic active_mode;
	logic lowcur_on;
	assign two_channel = init_sel == bfs_pkg::BFS_DUAL_CHANNEL_UNSUPERVISED
		|| init_sel == bfs_pkg::BFS_DUAL_CHANNEL_SUPERVISED;
	assign supervised = init_sel == bfs_pkg::BFS_SINGLE_CHANNEL_SUPERVISED
		|| init_sel == bfs_pkg::BFS_DUAL_CHANNEL_SUPERVISED;
	assign start_any = |s_phase || s_three;
	assign started = start_any && (!two_channel || s_rel);
	assign multi_pole = s_three || (s_phase != 3'b001 && s_phase != 3'b010
		&& s_phase != 3'b100);
	assign query_mode = op_mode == bfs_pkg::BFS_CURRENT_QUERY
		|| op_mode == bfs_pkg::BFS_TRIP_REP_QUERY;
	assign repeat_mode = op_mode == bfs_pkg::BFS_TRIP_REP_QUERY
		|| op_mode == bfs_pkg::BFS_TRIP_REP_UNBALANCE;
	assign active_mode = query_mode || op_mode == bfs_pkg::BFS_ZONE_UNBALANCE_MODE
		|| op_mode == bfs_pkg::BFS_TRIP_REP_UNBALANCE;
	assign lowcur_on = low_current_enable && active_mode;

	// per-phase release: initiating phase plus one more current; with repeat_three_pole, phase-earth plus earth current
	logic [2:0] phase_rel;
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			if (repeat_three_pole)
				phase_rel[i] = s_iph_ef[i] && s_ie;
			else
				phase_rel[i] = s_iph[i] && ((|(s_iph & ~(3'b001 << i))) || s_ie);
		end
	end
	logic raw_current;
	assign raw_current = |phase_rel || (s_three && |s_iph);

	// dropout hold keeps the release alive briefly after current vanishes
	logic        drop_hold;
	logic [4:0]  drop_count;
	logic [4:0]  next_drop_count;
	logic [4:0]  drop_limit;
	assign drop_limit = query_mode ? 5'(bfs_pkg::QUERY_DROP_MS)
		: 5'(bfs_pkg::UNBAL_DROP_MS);
	always_comb begin
		next_drop_count = drop_count;
		if (raw_current) next_drop_count = drop_limit;
		else if (tick && drop_count != 5'h00) next_drop_count = drop_count - 5'h01;
	end
	always_ff @(posedge CLK) begin
		if (RESET) drop_count <= 5'h00;
		else drop_count <= next_drop_count;
	end
	assign drop_hold = raw_current || drop_count != 5'h00;

	// -----------------------------------------------------------------
	// timers
	// -----------------------------------------------------------------
	logic run_main;
	logic run_low;
	logic run_pulse;
	logic [14:0] fail_ms;
	assign run_main  = started && active_mode && drop_hold;
	assign run_low   = lowcur_on && started && s_closed && !(|s_iph);
	assign run_pulse = pulse_enable && repeat_mode && s_pulse && drop_hold;
	always_comb begin
		if (s_nready) fail_ms = to_ms(breaker_fault_delay);
		else if (multi_pole) fail_ms = to_ms(multi_pole_delay);
		else fail_ms = to_ms(single_pole_delay);
	end

	logic rep_done;
	logic fail_done;
	logic low_rep_done;
	logic low_done;
	logic pulse_rep_done;
	logic pulse_fail_done;
	bfs_timer u_rep (.clk(CLK), .reset(RESET), .tick(tick), .run(run_main),
		.limit_ms(to_ms(repeat_delay)), .expired(rep_done));
	bfs_timer u_fail (.clk(CLK), .reset(RESET), .tick(tick), .run(run_main),
		.limit_ms(fail_ms), .expired(fail_done));
	bfs_timer u_lrep (.clk(CLK), .reset(RESET), .tick(tick), .run(run_low),
		.limit_ms(to_ms(repeat_delay)), .expired(low_rep_done));
	bfs_timer u_low (.clk(CLK), .reset(RESET), .tick(tick), .run(run_low),
		.limit_ms(to_ms(low_current_delay)), .expired(low_done));
	bfs_timer u_prep (.clk(CLK), .reset(RESET), .tick(tick), .run(run_pulse),
		.limit_ms(to_ms(pulse_mode_delay)), .expired(pulse_rep_done));
	bfs_timer u_pfail (.clk(CLK), .reset(RESET), .tick(tick), .run(run_pulse),
		.limit_ms(to_ms(pulse_mode_delay) + fail_ms), .expired(pulse_fail_done));

	// supervision timers
	logic rel_long;
	logic win_done;
	logic pulse_long;
	logic pulse_short_ok;
	bfs_timer u_rsup (.clk(CLK), .reset(RESET), .tick(tick), .run(supervised && s_rel),
		.limit_ms(to_ms(release_supervision_time)), .expired(rel_long));
	bfs_timer u_win (.clk(CLK), .reset(RESET), .tick(tick),
		.run(two_channel && supervised && start_any && !s_rel),
		.limit_ms(to_ms(two_channel_window)), .expired(win_done));
	bfs_timer u_pmax (.clk(CLK), .reset(RESET), .tick(tick), .run(s_pulse),
		.limit_ms(15'(bfs_pkg::PULSE_MAX_MS)), .expired(pulse_long));
	bfs_timer u_pmin (.clk(CLK), .reset(RESET), .tick(tick), .run(s_pulse),
		.limit_ms(15'(bfs_pkg::PULSE_MIN_MS)), .expired(pulse_short_ok));

	// -----------------------------------------------------------------
	// outputs
	// -----------------------------------------------------------------
	logic       pulse_d;
	logic       pulse_min_seen;
	logic [2:0] next_trip_repeat;
	logic       next_bus;
	logic       next_rel_err;
	logic       next_win_err;
	logic       next_pulse_err;
	logic       pulse_short;
	assign pulse_short = pulse_d && !s_pulse && !pulse_min_seen;
	always_comb begin
		next_trip_repeat = 3'b000;
		if (repeat_mode && rep_done && !s_nready)
			next_trip_repeat = (multi_pole || repeat_three_pole) ? 3'b111 : phase_rel;
		if (low_rep_done) next_trip_repeat = 3'b111;
		if (pulse_rep_done && !s_nready) next_trip_repeat = 3'b111;
		next_bus = op_mode == bfs_pkg::BFS_EXTERNAL ? started
			: (fail_done || low_done || pulse_fail_done);
		// set wins over clear: flags are sticky until reset or error-register write
		next_rel_err   = RELEASE_ERROR || rel_long;
		next_win_err   = TWO_CHANNEL_ERROR || win_done;
		next_pulse_err = PULSE_ERROR || pulse_long || pulse_short;
		if (wr && PADDR == bfs_pkg::ADDR_ERROR) begin
			next_rel_err   = (RELEASE_ERROR && !PWDATA[0]) || rel_long;
			next_win_err   = (TWO_CHANNEL_ERROR && !PWDATA[1]) || win_done;
			next_pulse_err = (PULSE_ERROR && !PWDATA[2]) || pulse_long || pulse_short;
		end
	end
	always_ff @(posedge CLK) begin
		if (RESET) begin
			TRIP_REPEAT       <= 3'b000;
			BUS_ZONE_TRIP     <= 1'b0;
			TRANSFER_TRIP     <= 1'b0;
			RELEASE_ERROR     <= 1'b0;
			TWO_CHANNEL_ERROR <= 1'b0;
			PULSE_ERROR       <= 1'b0;
			pulse_d           <= 1'b0;
			pulse_min_seen    <= 1'b0;
		end else begin
			TRIP_REPEAT       <= next_trip_repeat;
			BUS_ZONE_TRIP     <= next_bus;
			TRANSFER_TRIP     <= next_bus && op_mode != bfs_pkg::BFS_EXTERNAL;
			RELEASE_ERROR     <= next_rel_err;
			TWO_CHANNEL_ERROR <= next_win_err;
			PULSE_ERROR       <= next_pulse_err;
			pulse_d           <= s_pulse;
			pulse_min_seen    <= s_pulse && pulse_short_ok;
		end
	end

	// -----------------------------------------------------------------
	// apb read side
	// -----------------------------------------------------------------
	logic [31:0] next_prdata;
	always_comb begin
		next_prdata = 32'h0000_0000;
		unique case (PADDR)
			bfs_pkg::ADDR_CONTROL: next_prdata = 32'({pulse_enable, repeat_three_pole,
				low_current_enable, op_mode, init_sel});
			bfs_pkg::ADDR_SINGLE_POLE: next_prdata = 32'(single_pole_delay);
			bfs_pkg::ADDR_MULTI_POLE:  next_prdata = 32'(multi_pole_delay);
			bfs_pkg::ADDR_LOW_CURRENT: next_prdata = 32'(low_current_delay);
			bfs_pkg::ADDR_PULSE_MODE:  next_prdata = 32'(pulse_mode_delay);
			bfs_pkg::ADDR_BREAKER_FLT: next_prdata = 32'(breaker_fault_delay);
			bfs_pkg::ADDR_REPEAT:      next_prdata = 32'(repeat_delay);
			bfs_pkg::ADDR_RELEASE_SUP: next_prdata = 32'(release_supervision_time);
			bfs_pkg::ADDR_TWO_CHANNEL: next_prdata = 32'(two_channel_window);
			bfs_pkg::ADDR_STATUS: next_prdata = 32'({started, TRANSFER_TRIP,
				BUS_ZONE_TRIP, TRIP_REPEAT});
			bfs_pkg::ADDR_ERROR: next_prdata = 32'({PULSE_ERROR, TWO_CHANNEL_ERROR,
				RELEASE_ERROR});
			default: next_prdata = 32'h0000_0000;
		endcase
	end
	logic unmapped;
	assign unmapped = PADDR > bfs_pkg::ADDR_ERROR || PADDR[1:0] != 2'b00;
	// one wait state: answer registered in the access cycle
	always_ff @(posedge CLK) begin
		if (RESET) begin
			PRDATA  <= 32'h0000_0000;
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
		end else begin
			PREADY  <= PSEL && PENABLE && !PREADY;
			PSLVERR <= PSEL && PENABLE && !PREADY && unmapped;
			PRDATA  <= next_prdata;
		end
	end
endmodule : bfs_supervisor
`default_nettype wire

// file: dv/bfs_props.sv
`timescale 1ns/10ps
`default_nettype none
module bfs_props #(
	parameter int TICK_CYCLES = bfs_pkg::TICK_CYCLES
) (
	input wire logic	CLK,
	input wire logic	RESET,
	input wire logic	PSEL,
	input wire logic	PENABLE,
	input wire logic	PWRITE,
	input wire logic [7:0]	PADDR,
	input wire logic [31:0]	PWDATA,
	input wire logic	PREADY,
	input wire logic	PSLVERR,
	input wire logic [2:0]	START_PHASE,
	input wire logic	START_THREE_POLE,
	input wire logic	REMOTE_PULSE_INPUT,
	input wire logic	BREAKER_NOT_READY_INPUT,
	input wire logic [2:0]	TRIP_REPEAT,
	input wire logic	BUS_ZONE_TRIP,
	input wire logic	TRANSFER_TRIP,
	input wire logic	RELEASE_ERROR,
	input wire logic	TWO_CHANNEL_ERROR
);
	// ------
	// shadow control, age of start
	// ------
	logic [7:0]	ctl;
	logic [7:0]	next_ctl;
	int	age;
	int	next_age;
	always_comb begin
		next_ctl = ctl;
		if (PSEL && PENABLE && PREADY && PWRITE && PADDR == bfs_pkg::ADDR_CONTROL)
			next_ctl = PWDATA[7:0];
		next_age = (|START_PHASE || START_THREE_POLE || REMOTE_PULSE_INPUT) ? age + 1 : 0;
	end
	always_ff @(posedge CLK) begin
		ctl <= RESET ? 8'h09 : next_ctl;
		age <= RESET ? 0 : next_age;
	end
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);
	sequence acc_s;
		PSEL && PENABLE && !PREADY;
	endsequence
	sequence none_s;
		(ctl[4:2] == 3'h0) [*4];
	endsequence
	sequence hold_s;
		(BREAKER_NOT_READY_INPUT && !ctl[5]) [*4];
	endsequence
	chk_reset_clears: assert property (
		disable iff (1'b0) RESET |=> !BUS_ZONE_TRIP && !TRANSFER_TRIP && TRIP_REPEAT == 3'h0
		&& !RELEASE_ERROR && !TWO_CHANNEL_ERROR) else $error("output set after reset");
	chk_one_wait: assert property (acc_s |=> PREADY) else $error("pready late");
	chk_err_pair: assert property (PSLVERR |-> PREADY) else $error("pslverr alone");
	chk_none_quiet: assert property (
		none_s |-> !BUS_ZONE_TRIP && !TRANSFER_TRIP && TRIP_REPEAT == 3'h0) else $error("trip off");
	chk_hold_norep: assert property (
		hold_s |-> TRIP_REPEAT == 3'h0) else $error("repeat while not ready");
	chk_ext_fast: assert property (
		$rose(START_THREE_POLE) && ctl[4:2] == 3'h1 && !ctl[1] |-> ##[1:6] BUS_ZONE_TRIP)
		else $error("external trip slow");
	chk_min_delay: assert property (
		$rose(BUS_ZONE_TRIP) && ctl[4:2] > 3'h1 && !BREAKER_NOT_READY_INPUT
		|-> age >= 50 * TICK_CYCLES) else $error("bus trip early");
	chk_window_sup: assert property (
		$rose(TWO_CHANNEL_ERROR) |-> ctl[1:0] == 2'h3) else $error("window error");
	chk_release_sup: assert property (
		$rose(RELEASE_ERROR) |-> ctl[0]) else $error("release error");
endmodule : bfs_props
bind bfs_supervisor bfs_props #(.TICK_CYCLES(TICK_CYCLES)) bfs_props_inst (.CLK(CLK),
	.RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
	.PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .START_PHASE(START_PHASE),
	.START_THREE_POLE(START_THREE_POLE), .REMOTE_PULSE_INPUT(REMOTE_PULSE_INPUT),
	.BREAKER_NOT_READY_INPUT(BREAKER_NOT_READY_INPUT), .TRIP_REPEAT(TRIP_REPEAT),
	.BUS_ZONE_TRIP(BUS_ZONE_TRIP), .TRANSFER_TRIP(TRANSFER_TRIP),
	.RELEASE_ERROR(RELEASE_ERROR), .TWO_CHANNEL_ERROR(TWO_CHANNEL_ERROR));
`default_nettype wire

// file: dv/bfs_bay.sv
`timescale 1ns/10ps
`default_nettype none
// bay levels follow the command word; bench changes it on clock edges
module bfs_bay (
	input wire logic [11:0]	cmd,
	output logic [2:0]	sp,
	output logic [2:0]	cp,
	output logic [3:0]	flags,
	output logic	rl,
	output logic	pu
);
	assign sp = cmd[2:0];
	assign cp = cmd[5:3];
	assign flags = cmd[9:6];
	assign rl = cmd[10];
	assign pu = cmd[11];
endmodule : bfs_bay
`default_nettype wire

// file: dv/bfs_supervisor_tb.sv
`timescale 1ns/10ps
`default_nettype none
module bfs_supervisor_tb;
	logic	CLK = 1'b0;
	logic	RESET = 1'b1;
	logic	PSEL = 1'b0;
	logic	PENABLE = 1'b0;
	logic	PWRITE = 1'b0;
	logic [7:0]	PADDR = 8'h00;
	logic [31:0]	PWDATA = 32'h0;
	logic [31:0]	PRDATA;
	logic	PREADY, PSLVERR, BZ, TT, RE, WE, PE, rl, pu;
	logic [2:0]	TR, sp, cp;
	logic [3:0]	fl;
	logic [11:0]	cmd = 12'h000;
	int	err_count = 0;
	int	cmp_count = 0;
	localparam int MN[8] = '{5, 5, 5, 5, 0, 0, 2, 6};
	localparam int MX[8] = '{1000, 1000, 1000, 1000, 1000, 1000, 1500, 100};
	localparam int RS[8] = '{25, 25, 25, 50, 10, 12, 1500, 6};
	localparam logic [19:0] SC[12] = '{20'h09089, 20'h0D089, 20'h4D089, 20'h0D189,
		20'h01089, 20'h050C8, 20'h090C8, 20'h11089, 20'h11001, 20'h29201, 20'h0B089, 20'h0A489};
	always #50 CLK = ~CLK;
	bfs_bay bfs_bay_inst (.cmd(cmd), .sp(sp), .cp(cp), .flags(fl), .rl(rl), .pu(pu));
	bfs_supervisor #(.TICK_CYCLES(10)) bfs_supervisor_inst (.CLK(CLK), .RESET(RESET),
		.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
		.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .START_PHASE(sp),
		.START_THREE_POLE(fl[0]), .FAILURE_RELEASE_INPUT(rl), .REMOTE_PULSE_INPUT(pu),
		.BREAKER_NOT_READY_INPUT(fl[2]), .BREAKER_CLOSED(fl[3]), .PHASE_ABOVE_THRESHOLD(cp),
		.PHASE_ABOVE_EARTH_THRESHOLD(cp), .EARTH_ABOVE_THRESHOLD(fl[1]), .TRIP_REPEAT(TR),
		.BUS_ZONE_TRIP(BZ), .TRANSFER_TRIP(TT), .RELEASE_ERROR(RE), .TWO_CHANNEL_ERROR(WE),
		.PULSE_ERROR(PE));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge CLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		do @(posedge CLK); while (PREADY !== 1'b1);
		q = PRDATA;
		e = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask : apb
	task automatic wait_ms(input int n);
		repeat (n * 10) @(posedge CLK);
	endtask : wait_ms
	// ------
	// reference model: bus trip delay in ms, -1 for none
	// ------
	function automatic int bus_ms(input logic [7:0] c, input logic [11:0] k);
		if (c[4:2] == 3'h0 || (c[1] && !k[10])) return -1;
		if (c[4:2] == 3'h1) return 0;
		if (c[5] && k[9] && k[5:3] == 3'h0) return 10 * RS[2];
		if (k[5:3] == 3'h0 && !k[7] && c[4:2] > 3'h3 && !c[5]) return -1;
		return k[8] ? 100 : (k[6] ? 200 : 250);
	endfunction : bus_ms
	task automatic scen(input logic [7:0] c, input logic [11:0] k);
		logic [31:0]	q;
		logic	e;
		int	d;
		int	tr;
		d = bus_ms(c, k);
		apb(1'b1, bfs_pkg::ADDR_CONTROL, {24'h0, c}, q, e);
		cmd <= k;
		wait_ms(125);
		tr = (c[4:2] == 3 || c[4:2] == 5) && !k[8] ? (c[6] ? 7 : k[2:0]) : 0;
		if (c[5] && c[4:2] > 1 && k[9] && k[5:3] == 0) tr = 7;
		chk(TR, tr);
		chk({PE, WE, RE}, c[1:0] == 2'h3 ? 2 : 0);
		if (d > 125) begin
			wait_ms(d - 130);
			chk(BZ, 0);
			wait_ms(10);
			chk(TT, 1);
		end
		chk(BZ, d >= 0);
		cmd <= 12'h000;
		wait_ms(40);
		apb(1'b1, bfs_pkg::ADDR_ERROR, 32'h7, q, e);
	endtask : scen
	task automatic tally_and_finish();
		$display("errors %0d of %0d compares", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : tally_and_finish
	initial begin
		#8_000_000;
		err_count++;
		tally_and_finish();
	end
	initial begin
		logic [31:0]	q;
		logic	e;
		int	v;
		void'($urandom(26187));
		repeat (8) @(posedge CLK);
		RESET <= 1'b0;
		apb(1'b0, bfs_pkg::ADDR_CONTROL, 32'h0, q, e);
		chk(q, 32'h09);
		apb(1'b0, 8'h2C, 32'h0, q, e);
		chk(32'(e), 32'h1);
		for (int i = 0; i < 8; i++) begin
			apb(1'b0, 8'(4 * i + 4), 32'h0, q, e);
			chk(q, RS[i]);
			v = $urandom % 1600;
			apb(1'b1, 8'(4 * i + 4), v, q, e);
			apb(1'b0, 8'(4 * i + 4), 32'h0, q, e);
			chk(q, v < MN[i] ? MN[i] : (v > MX[i] ? MX[i] : v));
			apb(1'b1, 8'(4 * i + 4), i == 1 ? 20 : RS[i], q, e);
		end
		foreach (SC[j]) scen(SC[j][19:12], SC[j][11:0]);
		apb(1'b1, bfs_pkg::ADDR_CONTROL, 32'h8D, q, e);
		apb(1'b1, bfs_pkg::ADDR_RELEASE_SUP, 32'h2, q, e);
		cmd <= 12'h400;
		wait_ms(30);
		chk(RE, 1'b1);
		cmd <= 12'h800;
		wait_ms(5);
		cmd <= 12'h000;
		wait_ms(5);
		chk(PE, 1'b1);
		tally_and_finish();
	end
endmodule : bfs_supervisor_tb
`default_nettype wire
